//--- uart_alias_pkg.sv
// Summary of operation
// - Sixteen word locations alias one data port.
// - Read returns received byte, serial or infrared.
// - Read data valid only while data ready.
// - FIFOs off: new byte overwrites, flags overrun.
// - FIFOs on: read pops oldest receive entry.
// - Receive FIFO full: drop new byte, overrun.
// - Written byte goes out serial or infrared.
// - FIFOs off: one write clears holding empty.
// - FIFOs off: further write overwrites pending byte.
// - FIFOs on: sixteen writes before FIFO full.
// - Write to full transmit FIFO is discarded.
package uart_alias_pkg;
    // Clock and line timing; the bit time is derived from both rates.
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned BAUD_RATE     = 115_200;
    localparam logic [11:0] BIT_CYCLES    = 12'(CLK_HZ / BAUD_RATE);
    localparam logic [11:0] HALF_BIT      = 12'(CLK_HZ / BAUD_RATE / 2);
    localparam logic [11:0] IR_PULSE      = 12'(CLK_HZ / BAUD_RATE * 3 / 16);
    localparam logic [11:0] CNT_ONE       = 12'h001;
    // Character path and FIFO geometry.
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W      = 4;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  FIFO_FULL  = 5'h10;
    localparam logic [2:0]  LAST_BIT   = 3'h7;
    // Register byte addresses.
    localparam logic [31:0] ALIAS_BASE   = 32'h5000_1030;
    localparam logic [31:0] ALIAS_END    = 32'h5000_1070;
    localparam logic [31:0] ALIAS_12     = 32'h5000_1060;
    localparam logic [31:0] FIFO_CTL_ADR = 32'h5000_1008;
    localparam logic [31:0] MODE_ADR     = 32'h5000_1010;
    localparam logic [31:0] LINE_ST_ADR  = 32'h5000_1014;
    localparam logic [31:0] INT_ST_ADR   = 32'h5000_1080;
    localparam logic [31:0] INT_MASK_ADR = 32'h5000_1084;
    // Field positions.
    localparam int unsigned FCTL_EN_BIT    = 0;
    localparam int unsigned FCTL_RXRST_BIT = 1;
    localparam int unsigned FCTL_TXRST_BIT = 2;
    localparam int unsigned MODE_IR_BIT    = 0;
    localparam int unsigned LST_RDY_BIT    = 0;
    localparam int unsigned LST_OVR_BIT    = 1;
    localparam int unsigned LST_TXE_BIT    = 5;
    localparam int unsigned LST_TEMT_BIT   = 6;
    localparam int unsigned INT_W          = 4;
endpackage

//--- uart_alias_if.sv
`timescale 1ns/1ns
// Character FIFO port: the owner pushes and pops, the store answers.
interface fifo_if;
    logic       push;   // Enqueue push_data this cycle.
    logic [7:0] push_data;
    logic       pop;    // Drop the head entry this cycle.
    logic [7:0] head;   // Oldest entry.
    logic       full;
    logic       empty;
    modport owner (output push, push_data, pop, input head, full, empty);
    modport store (input push, push_data, pop, output head, full, empty);
endinterface // fifo_if

// Serialiser port: one start pulse per byte, one strobe per byte received.
interface serdes_if;
    logic       tx_go;
    logic [7:0] tx_byte;
    logic       tx_busy;
    logic       rx_stb;
    logic [7:0] rx_byte;
    logic       ir_mode;
    modport owner (output tx_go, tx_byte, ir_mode, input tx_busy, rx_stb, rx_byte);
    modport line (input tx_go, tx_byte, ir_mode, output tx_busy, rx_stb, rx_byte);
endinterface // serdes_if

//--- uart_char_fifo.sv
`timescale 1ns/1ns
// Sixteen-entry character queue in flip-flops; push when full is dropped.
module uart_char_fifo
    import uart_alias_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic flush,
    fifo_if.store    f
);
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0]                  wp;
        logic [PTR_W-1:0]                  rp;
        logic [CNT_W-1:0]                  cnt;
    } fifo_state_t;

    fifo_state_t s_r;   // Registered state.
    fifo_state_t s_nxt; // Next state.
    logic        do_push;
    logic        do_pop;

    // A full queue keeps its contents and ignores the push.
    always_comb begin
        s_nxt   = s_r;
        do_push = f.push && (s_r.cnt != FIFO_FULL);
        do_pop  = f.pop && (s_r.cnt != '0);
        if (flush) begin
            s_nxt.wp  = '0;
            s_nxt.rp  = '0;
            s_nxt.cnt = '0;
        end else begin
            if (do_push) begin
                s_nxt.mem[s_r.wp] = f.push_data;
                s_nxt.wp          = s_r.wp + PTR_W'(1);
            end
            if (do_pop) begin
                s_nxt.rp = s_r.rp + PTR_W'(1);
            end
            s_nxt.cnt = s_r.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    // Single register stage for the whole state.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign f.head  = s_r.mem[s_r.rp];
    assign f.full  = (s_r.cnt == FIFO_FULL);
    assign f.empty = (s_r.cnt == '0);
endmodule // uart_char_fifo

//--- uart_serdes.sv
`timescale 1ns/1ns
// Eight data bits, no parity, one stop bit, fixed bit time.
module uart_serdes
    import uart_alias_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic sin,
    input  wire logic sir_in,
    output logic      sout,
    output logic      sir_out_n,
    serdes_if.line    p
);
    typedef enum logic [1:0] {IDLE, START, DATA, STOP} bit_state_t;
    typedef struct packed {
        logic       sin_m;    // First synchroniser stages.
        logic       sin_s;
        logic       ir_m;
        logic       ir_s;
        bit_state_t tx_st;
        logic [11:0] tx_cnt;
        logic [7:0] tx_sh;
        logic [2:0] tx_idx;
        logic       sout_n;   // Inverted so that reset gives an idle high line.
        logic       sir_out;  // Inverted so that reset gives an idle high pin.
        bit_state_t rx_st;
        logic [11:0] rx_cnt;
        logic [7:0] rx_sh;
        logic [2:0] rx_idx;
        logic       rx_stb;
        logic [7:0] rx_byte;
    } serdes_state_t;

    serdes_state_t s_r;
    serdes_state_t s_nxt;
    logic          rx_line;
    logic          tx_bit;

    // The infrared receiver is taken to deliver a high level for a zero bit.
    always_comb begin
        s_nxt        = s_r;
        s_nxt.sin_m  = sin;
        s_nxt.sin_s  = s_r.sin_m;
        s_nxt.ir_m   = sir_in;
        s_nxt.ir_s   = s_r.ir_m;
        s_nxt.rx_stb = 1'b0;
        rx_line      = p.ir_mode ? !s_r.ir_s : s_r.sin_s;
        // Transmitter: advance one bit each bit time.
        unique case (s_r.tx_st)
            IDLE: begin
                if (p.tx_go) begin
                    s_nxt.tx_st  = START;
                    s_nxt.tx_sh  = p.tx_byte;
                    s_nxt.tx_cnt = '0;
                end
            end
            START, DATA, STOP: begin
                s_nxt.tx_cnt = s_r.tx_cnt + CNT_ONE;
                if (s_r.tx_cnt == BIT_CYCLES - CNT_ONE) begin
                    s_nxt.tx_cnt = '0;
                    if (s_r.tx_st == START) begin
                        s_nxt.tx_st  = DATA;
                        s_nxt.tx_idx = '0;
                    end else if (s_r.tx_st == DATA) begin
                        s_nxt.tx_sh  = s_r.tx_sh >> 1;
                        s_nxt.tx_idx = s_r.tx_idx + 3'(1);
                        if (s_r.tx_idx == LAST_BIT) begin
                            s_nxt.tx_st = STOP;
                        end
                    end else begin
                        s_nxt.tx_st = IDLE;
                    end
                end
            end
        endcase
        tx_bit        = (s_nxt.tx_st == START) ? 1'b0 :
                        (s_nxt.tx_st == DATA) ? s_nxt.tx_sh[0] : 1'b1;
        s_nxt.sout_n  = !(p.ir_mode || tx_bit);
        s_nxt.sir_out = p.ir_mode && !tx_bit && (s_nxt.tx_cnt < IR_PULSE);
        // Receiver: check the start bit at mid-bit, then sample each bit centre.
        unique case (s_r.rx_st)
            IDLE: begin
                if (!rx_line) begin
                    s_nxt.rx_st  = START;
                    s_nxt.rx_cnt = '0;
                end
            end
            START: begin
                s_nxt.rx_cnt = s_r.rx_cnt + CNT_ONE;
                if (s_r.rx_cnt == HALF_BIT) begin
                    s_nxt.rx_cnt = '0;
                    s_nxt.rx_idx = '0;
                    s_nxt.rx_st  = rx_line ? IDLE : DATA;
                end
            end
            DATA, STOP: begin
                s_nxt.rx_cnt = s_r.rx_cnt + CNT_ONE;
                if (s_r.rx_cnt == BIT_CYCLES - CNT_ONE) begin
                    s_nxt.rx_cnt = '0;
                    if (s_r.rx_st == DATA) begin
                        s_nxt.rx_sh  = {rx_line, s_r.rx_sh[7:1]};
                        s_nxt.rx_idx = s_r.rx_idx + 3'(1);
                        if (s_r.rx_idx == LAST_BIT) begin
                            s_nxt.rx_st = STOP;
                        end
                    end else begin
                        // A low stop bit is a framing fault; the byte is dropped.
                        s_nxt.rx_stb  = rx_line;
                        s_nxt.rx_byte = s_r.rx_sh;
                        s_nxt.rx_st   = IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sout      = !s_r.sout_n;
    assign sir_out_n = !s_r.sir_out;
    assign p.tx_busy = (s_r.tx_st != IDLE);
    assign p.rx_stb  = s_r.rx_stb;
    assign p.rx_byte = s_r.rx_byte;
endmodule // uart_serdes

//--- uart_shadow_data_alias.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// Data port of the serial block, reached at sixteen aliased word
// addresses, with the line status, FIFO control, mode and interrupt
// registers that steer it. The serialiser and both queues are
// instantiated below.
module uart_shadow_data_alias
    import uart_alias_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rdata,
    output logic             irq,
    input  wire logic        sin,
    input  wire logic        sir_in,
    output logic             sout,
    output logic             sir_out_n
);
    // All control state of the block, registered in one place.
    // Every field resets to zero, so the reset value is simply zero.
    typedef struct packed {
        logic [31:0]      rdata;      // Read answer, valid one cycle after the strobe.
        logic [7:0]       rxh;        // Receive holding register.
        logic             rdy;        // Holding register full, queues off.
        logic [7:0]       txh;        // Transmit holding register.
        logic             txh_full;   // Transmit character pending, queues off.
        logic             fifo_en;    // Queues enabled.
        logic             ir_mode;    // Infrared line selected.
        logic             overrun;    // Overrun error, cleared by a status read.
        logic             txe_low_d;  // Holding empty was low last cycle.
        logic [INT_W-1:0] int_st;     // Sticky event bits.
        logic [INT_W-1:0] int_mask;   // Event enables.
        logic             irq;        // Registered interrupt level.
    } top_state_t;

    top_state_t s_r;   // Registered state.
    top_state_t s_nxt; // Next state.

    // Bus decode strobes.
    logic rd_alias;
    logic wr_alias;
    logic rd_stat;
    // Internal status and events.
    logic             rdy_now;
    logic             txe_now;
    logic             ovr_ev;
    logic             drop_ev;
    logic             rx_flush;
    logic             tx_flush;
    logic [INT_W-1:0] events;
    logic [INT_W-1:0] w1c;

    fifo_if   rxq ();
    fifo_if   txq ();
    serdes_if sd ();

    // True for any of the sixteen aligned words that alias the data port.
    // The same decode serves reads and writes, so bursts land in one path.
    function automatic logic is_alias(input logic [31:0] a);
        is_alias = (a >= ALIAS_BASE) && (a < ALIAS_END) && (a[1:0] == 2'h0);
    endfunction

    // Queue for received characters.
    uart_char_fifo u_rx_fifo (
        .mclk  (mclk),
        .reset (reset),
        .flush (rx_flush),
        .f     (rxq.store)
    );

    // Queue for characters waiting to be sent.
    uart_char_fifo u_tx_fifo (
        .mclk  (mclk),
        .reset (reset),
        .flush (tx_flush),
        .f     (txq.store)
    );

    // Bit-level transmitter and receiver.
    uart_serdes u_serdes (
        .mclk      (mclk),
        .reset     (reset),
        .sin       (sin),
        .sir_in    (sir_in),
        .sout      (sout),
        .sir_out_n (sir_out_n),
        .p         (sd.line)
    );

    // Next-state logic for the register file and the data path.
    always_comb begin
        s_nxt     = s_r;
        // Read data stand for exactly one cycle, zero otherwise.
        s_nxt.rdata = '0;
        rd_alias  = rd_en && is_alias(addr);
        wr_alias  = wr_en && is_alias(addr);
        rd_stat   = rd_en && (addr == LINE_ST_ADR);
        ovr_ev    = 1'b0;
        drop_ev   = 1'b0;
        rx_flush  = 1'b0;
        tx_flush  = 1'b0;
        w1c       = '0;
        // Queue and serialiser controls default to idle.
        rxq.push      = 1'b0;
        rxq.push_data = sd.rx_byte;
        rxq.pop       = 1'b0;
        txq.push      = 1'b0;
        txq.push_data = wdata[7:0];
        txq.pop       = 1'b0;
        sd.tx_go      = 1'b0;
        sd.tx_byte    = s_r.txh;
        sd.ir_mode    = s_r.ir_mode;

        // Receive side.
        if (s_r.fifo_en) begin
            // A full queue keeps its entries; the new byte is lost.
            rxq.push = sd.rx_stb && !rxq.full;
            ovr_ev   = sd.rx_stb && rxq.full;
            // A data read takes the oldest entry off the queue.
            rxq.pop  = rd_alias;
        end else begin
            // A read clears data ready; a byte arriving now sets it again.
            if (rd_alias) begin
                s_nxt.rdy = 1'b0;
            end
            if (sd.rx_stb) begin
                // Overwrite an unread byte and record the loss.
                s_nxt.rxh = sd.rx_byte;
                s_nxt.rdy = 1'b1;
                ovr_ev    = s_r.rdy && !rd_alias;
            end
        end
        // Data ready follows the queue when enabled, the holding flag otherwise.
        rdy_now = s_r.fifo_en ? !rxq.empty : s_r.rdy;

        // Transmit side.
        if (s_r.fifo_en) begin
            // The queue itself discards a push when it is full.
            txq.push   = wr_alias;
            drop_ev    = wr_alias && txq.full;
            sd.tx_go   = !sd.tx_busy && !txq.empty;
            txq.pop    = sd.tx_go;
            sd.tx_byte = txq.head;
        end else begin
            sd.tx_go = !sd.tx_busy && s_r.txh_full;
            if (sd.tx_go) begin
                s_nxt.txh_full = 1'b0;
            end
            // A new write replaces any character still pending and
            // drops holding empty at once; the write wins over a start.
            if (wr_alias) begin
                s_nxt.txh      = wdata[7:0];
                s_nxt.txh_full = 1'b1;
            end
        end
        // Software paces its writes on this flag.
        txe_now = s_r.fifo_en ? txq.empty : !s_r.txh_full;

        // Register reads; anything unmapped answers zero.
        if (rd_alias) begin
            // Only the low byte carries data; the upper bits read as zero.
            s_nxt.rdata[7:0] = s_r.fifo_en ? rxq.head : s_r.rxh;
        end else if (rd_stat) begin
            s_nxt.rdata[LST_RDY_BIT]  = rdy_now;
            s_nxt.rdata[LST_OVR_BIT]  = s_r.overrun;
            s_nxt.rdata[LST_TXE_BIT]  = txe_now;
            s_nxt.rdata[LST_TEMT_BIT] = txe_now && !sd.tx_busy;
        end else if (rd_en && (addr == FIFO_CTL_ADR)) begin
            s_nxt.rdata[FCTL_EN_BIT] = s_r.fifo_en;
        end else if (rd_en && (addr == MODE_ADR)) begin
            s_nxt.rdata[MODE_IR_BIT] = s_r.ir_mode;
        end else if (rd_en && (addr == INT_ST_ADR)) begin
            s_nxt.rdata[INT_W-1:0] = s_r.int_st;
        end else if (rd_en && (addr == INT_MASK_ADR)) begin
            s_nxt.rdata[INT_W-1:0] = s_r.int_mask;
        end

        // Register writes other than the data port.
        if (wr_en && (addr == FIFO_CTL_ADR)) begin
            s_nxt.fifo_en = wdata[FCTL_EN_BIT];
            // Switching queue mode flushes both queues so that no stale
            // character is mixed into the other mode's data path.
            rx_flush = wdata[FCTL_RXRST_BIT] || (wdata[FCTL_EN_BIT] != s_r.fifo_en);
            tx_flush = wdata[FCTL_TXRST_BIT] || (wdata[FCTL_EN_BIT] != s_r.fifo_en);
        end
        if (wr_en && (addr == MODE_ADR)) begin
            s_nxt.ir_mode = wdata[MODE_IR_BIT];
        end
        if (wr_en && (addr == INT_MASK_ADR)) begin
            s_nxt.int_mask = wdata[INT_W-1:0];
        end
        if (wr_en && (addr == INT_ST_ADR)) begin
            w1c = wdata[INT_W-1:0];
        end

        // Overrun: a status read clears it, but a new overrun wins.
        s_nxt.overrun = (s_r.overrun && !rd_stat) || ovr_ev;

        // Events: byte received, overrun, holding empty rising, write lost.
        s_nxt.txe_low_d = !txe_now;
        events = {drop_ev, txe_now && s_r.txe_low_d, ovr_ev, sd.rx_stb};
        // Write-one-to-clear; an event in the same cycle keeps its bit.
        s_nxt.int_st = (s_r.int_st & ~w1c) | events;
        // The level is registered so the output comes from a flip-flop.
        s_nxt.irq = |(s_nxt.int_st & s_nxt.int_mask);
    end

    // One register stage for the whole control state.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Top outputs come straight from the state register.
    assign rdata = s_r.rdata;
    assign irq   = s_r.irq;
endmodule // uart_shadow_data_alias

//--- uart_alias_checker.sv
`timescale 1ns/1ns
// Port-level watch on the data alias block; it sees only the top ports.
module uart_alias_checker
    import uart_alias_pkg::*;
(
    input logic        mclk,
    input logic        reset,
    input logic [31:0] addr,
    input logic [31:0] wdata,
    input logic        wr_en,
    input logic        rd_en,
    input logic [31:0] rdata,
    input logic        irq,
    input logic        sin,
    input logic        sir_in,
    input logic        sout,
    input logic        sir_out_n
);
    // Longer than a frame, so a saturated count means an idle line.
    localparam logic [14:0] IDLE_SAT = 15'h7530;
    logic        ir_r, fen_r;       // Mode and FIFO enable as written.
    logic [3:0]  mask_r;            // Interrupt mask as written.
    logic [14:0] idle_r;            // Cycles since the last data write.
    logic [15:0] lo_r, ir_lo_r;     // Low run lengths of both outputs.
    logic        alias_hit, mapped; // Data window hit; any register hit.
    assign alias_hit = addr >= ALIAS_BASE && addr < ALIAS_END;
    assign mapped = alias_hit || addr[31:2] inside {FIFO_CTL_ADR[31:2], MODE_ADR[31:2],
        LINE_ST_ADR[31:2], INT_ST_ADR[31:2], INT_MASK_ADR[31:2]};

    // Shadow the steering registers from the bus; the counters only run.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ir_r    <= 1'b0;
            fen_r   <= 1'b0;
            mask_r  <= 4'h0;
            idle_r  <= IDLE_SAT;
            lo_r    <= 16'h0000;
            ir_lo_r <= 16'h0000;
        end else begin
            ir_r    <= (wr_en && addr == MODE_ADR) ? wdata[MODE_IR_BIT] : ir_r;
            fen_r   <= (wr_en && addr == FIFO_CTL_ADR) ? wdata[FCTL_EN_BIT] : fen_r;
            mask_r  <= (wr_en && addr == INT_MASK_ADR) ? wdata[3:0] : mask_r;
            idle_r  <= (wr_en && alias_hit) ? 15'h0000 :
                       (idle_r == IDLE_SAT) ? idle_r : idle_r + 15'h0001;
            lo_r    <= sout ? 16'h0000 : lo_r + 16'h0001;
            ir_lo_r <= sir_out_n ? 16'h0000 : ir_lo_r + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_UPPER_ZERO: assert property (rd_en && alias_hit |=> rdata[31:8] == 24'h00_0000)
        else $error("upper byte not zero");
    AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 32'h0000_0000)
        else $error("data without read");
    AST_UNMAPPED: assert property (rd_en && !mapped |=> rdata == 32'h0000_0000)
        else $error("unmapped read data");
    AST_TX_START: assert property (wr_en && alias_hit && !fen_r && !ir_r && idle_r == IDLE_SAT |-> ##[1:3] !sout)
        else $error("no start bit");
    AST_SOUT_RUN: assert property ($rose(sout) |-> (lo_r % {4'h0, BIT_CYCLES}) == 16'h0000)
        else $error("bad low run");
    AST_IR_PULSE: assert property ($rose(sir_out_n) |-> ir_lo_r == {4'h0, IR_PULSE})
        else $error("bad pulse length");
    AST_IR_SOUT_HIGH: assert property (ir_r && $past(ir_r, 3) |-> sout)
        else $error("sout moved in infrared mode");
    AST_SIR_DARK: assert property (!ir_r && !$past(ir_r, 3) |-> sir_out_n)
        else $error("pulse in serial mode");
    AST_IRQ_MASKED: assert property (mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq)
        else $error("irq while masked");
endmodule // uart_alias_checker

bind uart_shadow_data_alias uart_alias_checker i_chk (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .irq(irq), .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n)
);

//--- uart_peer_model.sv
`timescale 1ns/1ns
// Remote peer: frames bytes onto sin or sir_in, decodes sout or sir_out_n.
module uart_peer_model
    import uart_alias_pkg::*;
(
    input  logic mclk,
    input  logic sout,
    input  logic sir_out_n,
    output logic sin,
    output logic sir_in
);
    // Serial idles high, infrared dark.
    initial begin
        sin    = 1'b1;
        sir_in = 1'b0;
    end

    // One 8N1 frame, LSB first; an infrared zero stays lit all bit long
    // because the receiver samples it at mid-bit.
    task automatic send(input logic [7:0] d, input logic ir);
        logic [9:0] frame;
        frame = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            sin    <= ir ? 1'b1 : frame[i];
            sir_in <= ir ? ~frame[i] : 1'b0;
            repeat (BIT_CYCLES - 1) @(posedge mclk);
        end
    endtask

    // Sample bit or pulse centres; return at the stop centre so that
    // the next start edge is not missed.
    task automatic recv(output logic [7:0] d, input logic ir);
        wait ((ir ? sir_out_n : sout) === 1'b0);
        repeat (ir ? IR_PULSE / 2 : HALF_BIT) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYCLES) @(posedge mclk);
            if (i < 8) begin
                d[i] = ir ? sir_out_n : sout;
            end
        end
    endtask
endmodule // uart_peer_model

//--- uart_shadow_data_alias_tb.sv
`timescale 1ns/1ns
// Self-checking bench: register accesses against a serial peer.
module uart_shadow_data_alias_tb
    import uart_alias_pkg::*;
;
    logic        mclk, reset, wr_en, rd_en, irq, sin, sir_in, sout, sir_out_n;
    logic [31:0] addr, wdata, rdata, v;
    logic [7:0]  b0, b1;    // Bytes decoded by the peer.
    int          fails;     // Mismatches counted.
    int          n_checks;  // Comparisons made.

    uart_shadow_data_alias i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .sin(sin), .sir_in(sir_in),
        .sout(sout), .sir_out_n(sir_out_n));
    uart_peer_model i_peer (.mclk(mclk), .sout(sout), .sir_out_n(sir_out_n), .sin(sin),
        .sir_in(sir_in));

    // Free-running clock.
    always #2 mclk = ~mclk;

    // One-cycle write strobe.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Read strobe; the answer stands only in the following cycle.
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 q = rdata;
    endtask

    // Four-state compare, so an unknown never matches.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Single exit of the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard beyond four frame times.
    initial begin
        repeat (98_000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end

    initial begin
        mclk  = 1'b0;
        reset = 1'b1;
        addr  = 32'h0000_0000;
        wdata = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd(ALIAS_12, v);
        chk("alias12_reset", 32'h0000_0000, v);
        rd(LINE_ST_ADR, v);
        chk("status_reset", 32'h0000_0060, v & 32'h0000_0063);
        rd(32'h5000_1100, v);
        chk("unmapped", 32'h0000_0000, v);
        $display("test reset done");
        // Serial, FIFOs off: two bytes arrive unread; of three writes, the first and the last go out.
        fork
            begin
                i_peer.send(8'h5A, 1'b0);
                i_peer.send(8'hC3, 1'b0);
            end
            begin
                i_peer.recv(b0, 1'b0);
                i_peer.recv(b1, 1'b0);
            end
            begin
                wr(ALIAS_12, 32'h1234_56A5);
                wr(ALIAS_BASE, 32'h0000_0011);
                rd(LINE_ST_ADR, v);
                chk("tx_empty_cleared", 32'h0000_0000, v & 32'h0000_0020);
                wr(ALIAS_END - 32'h0000_0004, 32'h0000_0022);
            end
        join
        chk("tx_first", 32'h0000_00A5, 32'(b0));
        chk("tx_overwrite", 32'h0000_0022, 32'(b1));
        rd(LINE_ST_ADR, v);
        chk("ready_overrun", 32'h0000_0003, v & 32'h0000_0003);
        rd(ALIAS_END - 32'h0000_0004, v);
        chk("rx_overwrite", 32'h0000_00C3, v);
        // Overrun interrupt raised, masked, then cleared.
        wr(INT_MASK_ADR, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        #1 chk("irq_raised", 32'h0000_0001, 32'(irq));
        wr(INT_MASK_ADR, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        #1 chk("irq_masked", 32'h0000_0000, 32'(irq));
        wr(INT_ST_ADR, 32'h0000_000F);
        rd(INT_ST_ADR, v);
        chk("int_cleared", 32'h0000_0000, v);
        $display("test serial done");
        // Infrared, FIFOs on: overfill the transmit queue, receive two bytes.
        wr(MODE_ADR, 32'h0000_0001);
        wr(FIFO_CTL_ADR, 32'h0000_0001);
        fork
            begin
                i_peer.send(8'h96, 1'b1);
                i_peer.send(8'h0F, 1'b1);
            end
            i_peer.recv(b0, 1'b1);
            for (int i = 0; i < 20; i++) begin
                wr(ALIAS_BASE + 32'(4 * (i % 16)), 32'h0000_0040 + 32'(i));
                if (i == 15 || i == 19) begin
                    rd(INT_ST_ADR, v);
                    chk("tx_fifo_lost", (i == 19) ? 32'h0000_0008 : 32'h0000_0000,
                        v & 32'h0000_0008);
                end
            end
        join
        chk("ir_tx_byte", 32'h0000_0040, 32'(b0));
        rd(LINE_ST_ADR, v);
        chk("ready_set", 32'h0000_0001, v & 32'h0000_0001);
        rd(ALIAS_BASE, v);
        chk("fifo_oldest", 32'h0000_0096, v);
        rd(ALIAS_12, v);
        chk("fifo_next", 32'h0000_000F, v);
        rd(LINE_ST_ADR, v);
        chk("ready_drained", 32'h0000_0000, v & 32'h0000_0001);
        $display("test fifo infrared done");
        tally_and_finish();
    end
endmodule // uart_shadow_data_alias_tb
